// *** logic/arc_annunciator_defines.vh ***
// Purpose: Shared constants for the arc detector and annunciator
// Assumes: 100 MHz core clock, 16-bit samples and thresholds
// Notes:   Offsets are register word addresses on the plain port
`ifndef ARC_ANNUNCIATOR_DEFINES_VH
`define ARC_ANNUNCIATOR_DEFINES_VH
`define ADDR_W          4
`define DATA_W          16
`define REG_CTRL        4'h0
`define REG_OC_TH       4'h1
`define REG_VLOW_TH     4'h2
`define REG_IHIGH_TH    4'h3
`define REG_OC_COUNT    4'h4
`define REG_CROSS_COUNT 4'h5
`define REG_STATUS      4'h6
`define REG_IRQ_EN      4'h7
`define REG_IRQ_CLR     4'h8
`define REG_ALARM_CLR   4'h9
`define REG_COUNT_CLR   4'ha
`define CTRL_OC_EN      0
`define CTRL_CROSS_EN   1
`define CTRL_RESET      16'h0003
`define ST_OC_ARC       0
`define ST_CROSS_ARC    1
`define ST_ALARM        2
`define COUNT_MAX       16'hffff
`define BLINK_MS        20
`define BLINK_CYCLES    (`BLINK_MS * 100000)
`define ALARM_HALF_MS   250
`define ALARM_CYCLES    (`ALARM_HALF_MS * 100000)
`define BAR_SEGS        10
`endif

// *** logic/arc_counter.v ***
// Purpose: Saturating per-criterion arc counter
// Assumes: Count strobe is a single-cycle pulse per arc
// Notes:   A count arriving with a clear in the same cycle restarts the count at one
`timescale 1ns/1ns
`include "arc_annunciator_defines.vh"
module arc_counter (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        countPulse,
  input  wire        clear,
  output reg  [15:0] count_ff
);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
    end else if (countPulse) begin
      // Saturate so a flood of arcs never wraps to a small value
      if (clear) begin
        count_ff <= 16'h0001;
      end else if (count_ff != `COUNT_MAX) begin
        count_ff <= count_ff + 16'h0001;
      end
    end else if (clear) begin
      count_ff <= 16'h0000;
    end
  end
endmodule // arc_counter

// *** logic/bar_graph.v ***
// Purpose: Thermometer bar graph from a 16-bit level
// Assumes: Full scale is 16'hffff
// Notes:   Output registered
`timescale 1ns/1ns
`include "arc_annunciator_defines.vh"
module bar_graph (
  input  wire                   core_clk,
  input  wire                   rst,
  input  wire [15:0]            level,
  output reg  [`BAR_SEGS-1:0]   segs_ff
);
  wire [19:0] scaled = level * 4'ha;
  wire [3:0]  lit    = scaled[19:16];
  genvar g;
  generate
    for (g = 0; g < `BAR_SEGS; g = g + 1) begin : gSeg
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          segs_ff[g] <= 1'b0;
        end else begin
          segs_ff[g] <= (lit > g) || (level == 16'hffff);
        end
      end
    end
  endgenerate
endmodule // bar_graph

// *** logic/arc_annunciator.v ***
// Purpose: Arc detection, shutdown, arc counting and panel annunciation
// Assumes: Samples and status inputs synchronous to core_clk
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "arc_annunciator_defines.vh"
//////////////////////////////////////////////////////////////////////////////
module arc_annunciator (
  input  wire                 core_clk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   regAddr,
  input  wire [`DATA_W-1:0]   regWrData,
  input  wire                 regWrite,
  input  wire                 regRead,
  output reg  [`DATA_W-1:0]   regRdData_ff,
  input  wire [15:0]          outVoltage,
  input  wire [15:0]          outCurrent,
  input  wire [15:0]          outPower,
  input  wire [15:0]          peakVoltage,
  input  wire [15:0]          peakCurrent,
  input  wire [15:0]          peakPower,
  input  wire                 pulseStart,
  input  wire                 poweredUp,
  input  wire                 running,
  input  wire                 interlockOpen,
  input  wire                 doorOpen,
  input  wire [1:0]           regLoop,
  input  wire                 warning,
  input  wire                 alarm,
  input  wire                 anyButton,
  output reg                  shutdown_ff,
  output reg                  arcLed_ff,
  output reg                  alarmLed_ff,
  output reg                  buzzer_ff,
  output reg                  standbyLed_ff,
  output reg                  onLed_ff,
  output reg                  interlockLed_ff,
  output reg                  regULed_ff,
  output reg                  regILed_ff,
  output reg                  regPLed_ff,
  output wire [`BAR_SEGS-1:0] barVoltage,
  output wire [`BAR_SEGS-1:0] barCurrent,
  output wire [`BAR_SEGS-1:0] barPower,
  output reg                  irq_ff
);
  localparam [1:0] LOOP_POWER   = 2'b00;
  localparam [1:0] LOOP_VOLTAGE = 2'b01;
  localparam [1:0] LOOP_CURRENT = 2'b10;
  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_BLINK = 3'b010;
  localparam [2:0] S_GAP   = 3'b100;

  reg  [15:0] ctrl_ff;
  reg  [15:0] ocTh_ff;
  reg  [15:0] vLowTh_ff;
  reg  [15:0] iHighTh_ff;
  reg  [2:0]  status_ff;
  reg  [2:0]  irqEn_ff;
  reg         ocPrev_ff;
  reg         crossPrev_ff;
  reg  [15:0] pendingBlinks_ff;
  reg  [2:0]  blinkState_ff;
  reg  [21:0] blinkCnt_ff;
  reg  [24:0] alarmCnt_ff;
  reg         alarmPhase_ff;
  reg         critPrev_ff;
  wire [15:0] ocCount;
  wire [15:0] crossCount;

  function wrHit;
    input [`ADDR_W-1:0] a;
    begin
      wrHit = regWrite && (regAddr == a);
    end
  endfunction

  function loopIs;
    input [1:0] sel;
    begin
      loopIs = running && (regLoop == sel);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Detection: edges so each arc counts once even if it persists
  wire ocNow    = ctrl_ff[`CTRL_OC_EN] && (outCurrent > ocTh_ff);
  wire crossNow = ctrl_ff[`CTRL_CROSS_EN] && (outVoltage < vLowTh_ff)
                  && (outCurrent > iHighTh_ff);
  wire ocEvt    = ocNow && !ocPrev_ff;
  wire crossEvt = crossNow && !crossPrev_ff;
  wire anyEvt   = ocEvt || crossEvt;
  wire critical = alarm || warning;
  wire critRise = critical && !critPrev_ff;
  wire countClr = wrHit(`REG_COUNT_CLR);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocPrev_ff    <= 1'b0;
      crossPrev_ff <= 1'b0;
      shutdown_ff  <= 1'b0;
    end else begin
      ocPrev_ff    <= ocNow;
      crossPrev_ff <= crossNow;
      // Arc wins over pulse start so a new arc is never dropped
      if (anyEvt) begin
        shutdown_ff <= 1'b1;
      end else if (pulseStart) begin
        shutdown_ff <= 1'b0;
      end
    end
  end

  arc_counter uOcCounter (
    .core_clk   (core_clk),
    .rst        (rst),
    .countPulse (ocEvt),
    .clear      (countClr),
    .count_ff   (ocCount)
  );
  arc_counter uCrossCounter (
    .core_clk   (core_clk),
    .rst        (rst),
    .countPulse (crossEvt),
    .clear      (countClr),
    .count_ff   (crossCount)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff      <= `CTRL_RESET;
      ocTh_ff      <= 16'hffff;
      vLowTh_ff    <= 16'h0000;
      iHighTh_ff   <= 16'hffff;
      irqEn_ff     <= 3'h0;
      status_ff    <= 3'h0;
      regRdData_ff <= 16'h0000;
    end else begin
      if (wrHit(`REG_CTRL))     ctrl_ff    <= regWrData & `CTRL_RESET;
      if (wrHit(`REG_OC_TH))    ocTh_ff    <= regWrData;
      if (wrHit(`REG_VLOW_TH))  vLowTh_ff  <= regWrData;
      if (wrHit(`REG_IHIGH_TH)) iHighTh_ff <= regWrData;
      if (wrHit(`REG_IRQ_EN))   irqEn_ff   <= regWrData[2:0];
      // Set beats clear in the same cycle
      status_ff <= (status_ff & ~(wrHit(`REG_IRQ_CLR) ? regWrData[2:0] : 3'h0))
                   | {critRise, crossEvt, ocEvt};
      regRdData_ff <= 16'h0000;
      if (regRead) begin
        case (regAddr)
          `REG_CTRL:        regRdData_ff <= ctrl_ff;
          `REG_OC_TH:       regRdData_ff <= ocTh_ff;
          `REG_VLOW_TH:     regRdData_ff <= vLowTh_ff;
          `REG_IHIGH_TH:    regRdData_ff <= iHighTh_ff;
          `REG_OC_COUNT:    regRdData_ff <= ocCount;
          `REG_CROSS_COUNT: regRdData_ff <= crossCount;
          `REG_STATUS:      regRdData_ff <= {13'h0000, status_ff};
          `REG_IRQ_EN:      regRdData_ff <= {13'h0000, irqEn_ff};
          default:          regRdData_ff <= 16'h0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt: registered so the pin never glitches while status is written
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & irqEn_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arc LED: one blink per arc, queued since arcs outrun 20 ms blinks
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pendingBlinks_ff <= 16'h0000;
      blinkState_ff    <= S_IDLE;
      blinkCnt_ff      <= 22'h000000;
      arcLed_ff        <= 1'b0;
    end else begin
      if (anyEvt && !(blinkState_ff == S_IDLE && pendingBlinks_ff != 16'h0000)) begin
        if (pendingBlinks_ff != `COUNT_MAX) pendingBlinks_ff <= pendingBlinks_ff + 16'h0001;
      end else if (!anyEvt && blinkState_ff == S_IDLE && pendingBlinks_ff != 16'h0000) begin
        pendingBlinks_ff <= pendingBlinks_ff - 16'h0001;
      end
      case (blinkState_ff)
        S_IDLE: begin
          if (pendingBlinks_ff != 16'h0000) begin
            blinkState_ff <= S_BLINK;
            blinkCnt_ff   <= 22'h000000;
            arcLed_ff     <= 1'b1;
          end
        end
        S_BLINK: begin
          blinkCnt_ff <= blinkCnt_ff + 22'h000001;
          if (blinkCnt_ff == `BLINK_CYCLES - 1) begin
            blinkState_ff <= S_GAP;
            blinkCnt_ff   <= 22'h000000;
            arcLed_ff     <= 1'b0;
          end
        end
        S_GAP: begin
          blinkCnt_ff <= blinkCnt_ff + 22'h000001;
          if (blinkCnt_ff == `BLINK_CYCLES - 1) begin
            blinkState_ff <= S_IDLE;
          end
        end
        default: begin
          blinkState_ff <= S_IDLE;
          arcLed_ff     <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alarm LED blink and latched buzzer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmCnt_ff   <= 25'h0000000;
      alarmPhase_ff <= 1'b0;
      alarmLed_ff   <= 1'b0;
      buzzer_ff     <= 1'b0;
      critPrev_ff   <= 1'b0;
    end else begin
      critPrev_ff <= critical;
      if (!critical || alarmCnt_ff == `ALARM_CYCLES - 1) begin
        alarmCnt_ff <= 25'h0000000;
      end else begin
        alarmCnt_ff <= alarmCnt_ff + 25'h0000001;
      end
      if (!critical) begin
        alarmPhase_ff <= 1'b0;
      end else if (alarmCnt_ff == `ALARM_CYCLES - 1) begin
        alarmPhase_ff <= ~alarmPhase_ff;
      end
      alarmLed_ff <= critical && !alarmPhase_ff;
      // A new warning or alarm beats a button press in the same cycle
      if (critRise) begin
        buzzer_ff <= 1'b1;
      end else if (anyButton || wrHit(`REG_ALARM_CLR)) begin
        buzzer_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and regulator LEDs
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standbyLed_ff   <= 1'b0;
      onLed_ff        <= 1'b0;
      interlockLed_ff <= 1'b0;
      regULed_ff      <= 1'b0;
      regILed_ff      <= 1'b0;
      regPLed_ff      <= 1'b0;
    end else begin
      standbyLed_ff   <= poweredUp && !running;
      onLed_ff        <= running;
      interlockLed_ff <= interlockOpen || doorOpen;
      regULed_ff      <= loopIs(LOOP_VOLTAGE);
      regILed_ff      <= loopIs(LOOP_CURRENT);
      regPLed_ff      <= loopIs(LOOP_POWER);
    end
  end

  bar_graph uBarV (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (peakVoltage),
    .segs_ff  (barVoltage)
  );
  bar_graph uBarI (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (peakCurrent),
    .segs_ff  (barCurrent)
  );
  bar_graph uBarP (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (peakPower),
    .segs_ff  (barPower)
  );

  wire unusedPower = |outPower;
endmodule // arc_annunciator

// *** test/arc_annunciator_asserts.sv ***
// Purpose: Port-level checks for the arc annunciator
// Assumes: One clock domain, bound to every arc_annunciator
// Notes:   A new arc needs sample or register activity two cycles back
`timescale 1ns/1ns
module arc_annunciator_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        regWrite,
  input wire logic [15:0] outVoltage,
  input wire logic [15:0] outCurrent,
  input wire logic        pulseStart,
  input wire logic        poweredUp,
  input wire logic        running,
  input wire logic        interlockOpen,
  input wire logic        doorOpen,
  input wire logic [1:0]  regLoop,
  input wire logic        warning,
  input wire logic        alarm,
  input wire logic        anyButton,
  input wire logic        shutdown_ff,
  input wire logic        alarmLed_ff,
  input wire logic        buzzer_ff,
  input wire logic        standbyLed_ff,
  input wire logic        onLed_ff,
  input wire logic        interlockLed_ff,
  input wire logic        regULed_ff,
  input wire logic        regILed_ff,
  input wire logic        regPLed_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence alarmRise; $rose(warning || alarm); endsequence
  sequence quietTwo; !(warning || alarm) [*2]; endsequence
  //////////////////////////////////////////////////////////////////////////////
  shutdown_hold_a: assert property (shutdown_ff && !pulseStart |=> shutdown_ff)
    else $error("shutdown dropped without a pulse");
  shutdown_clear_a: assert property (shutdown_ff && pulseStart && $stable(outCurrent)
    && $stable(outVoltage) && !$past(regWrite) |=> !shutdown_ff)
    else $error("shutdown kept past pulse start");
  // Thresholds only move by writes, so a quiet bus and quiet samples mean no arc
  arc_cause_a: assert property ($rose(shutdown_ff) |-> $past(regWrite)
    || $past(regWrite, 2) || $past(outCurrent) != $past(outCurrent, 2)
    || $past(outVoltage) != $past(outVoltage, 2))
    else $error("shutdown with no cause");
  buzzer_start_a: assert property (alarmRise |=> buzzer_ff)
    else $error("buzzer not started");
  buzzer_cause_a: assert property ($rose(buzzer_ff) |-> $past(warning || alarm))
    else $error("buzzer started without warning");
  buzzer_silence_a: assert property (anyButton && !$rose(warning || alarm) |=> !buzzer_ff)
    else $error("buzzer kept after button");
  alarm_quiet_a: assert property (quietTwo |-> !alarmLed_ff)
    else $error("alarm led lit while quiet");
  power_leds_a: assert property (!rst |=> {standbyLed_ff, onLed_ff}
    == $past({poweredUp && !running, running}))
    else $error("power leds wrong");
  interlock_led_a: assert property (!rst |=> interlockLed_ff == $past(interlockOpen || doorOpen))
    else $error("interlock led wrong");
  reg_leds_a: assert property (!rst |=> {regULed_ff, regILed_ff, regPLed_ff} == $past(
    {running && regLoop == 2'h1, running && regLoop == 2'h2, running && regLoop == 2'h0}))
    else $error("regulator leds wrong");
endmodule // arc_annunciator_asserts
bind arc_annunciator arc_annunciator_asserts chkI (.core_clk, .rst, .regWrite, .outVoltage,
  .outCurrent, .pulseStart, .poweredUp, .running, .interlockOpen, .doorOpen, .regLoop, .warning,
  .alarm, .anyButton, .shutdown_ff, .alarmLed_ff, .buzzer_ff, .standbyLed_ff, .onLed_ff,
  .interlockLed_ff, .regULed_ff, .regILed_ff, .regPLed_ff);

// *** test/load_panel_model.sv ***
// Purpose: Chamber load samples and operator buttons
// Assumes: Kind bit0 overcurrent, bit1 low voltage with high current
// Notes:   Outputs move one edge after the request, like a sampling front end
`timescale 1ns/1ns
module load_panel_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  arcKind,
  input  wire logic        firePulse,
  input  wire logic        press,
  output logic      [15:0] outVoltage,
  output logic      [15:0] outCurrent,
  output logic             pulseStart,
  output logic             anyButton
);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outVoltage <= 16'h6000;
      outCurrent <= 16'h2000;
      pulseStart <= 1'h0;
      anyButton  <= 1'h0;
    end else begin
      outVoltage <= arcKind[1] ? 16'h0800 : 16'h6000;
      outCurrent <= arcKind[0] ? 16'h9000 : (arcKind[1] ? 16'h5000 : 16'h2000);
      pulseStart <= firePulse;
      anyButton  <= press;
    end
  end
endmodule // load_panel_model

// *** test/arc_annunciator_test.sv ***
// Purpose: Scenario bench for the arc annunciator
// Assumes: Thresholds oc 8000, vlow 1000, ihigh 4000 once set up
// Notes:   Blink periods outlast the run, so the arc led stays lit
`timescale 1ns/1ns
`include "arc_annunciator_defines.vh"
module arc_annunciator_test;
  logic core_clk, rst, pulseStart, anyButton, shutdown_ff, arcLed_ff, alarmLed_ff, buzzer_ff;
  logic standbyLed_ff, onLed_ff, interlockLed_ff, regULed_ff, regILed_ff, regPLed_ff, irq_ff;
  logic regWrite = 0, regRead = 0, firePulse = 0, press = 0, warning = 0, alarm = 0;
  logic poweredUp = 1, running = 1, interlockOpen = 0, doorOpen = 0;
  logic [1:0]  arcKind = 0, regLoop = 0;
  logic [3:0]  regAddr = 0;
  logic [15:0] regWrData = 0, peakVoltage = 0, peakCurrent = 0, peakPower = 0;
  logic [15:0] regRdData_ff, outVoltage, outCurrent;
  logic [9:0]  barVoltage, barCurrent, barPower;
  int          errTotal = 0, samplesChecked = 0, ocN = 0, crN = 0;
  arc_annunciator DUT (.*, .outPower(16'h0000));
  load_panel_model partner (.*);
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge core_clk);
    regRead <= 1'h0;
    #1;
    chk(regRdData_ff, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    logic [15:0] rv [8] = '{16'h0003, 16'hffff, 16'h0000, 16'hffff, 0, 0, 0, 0};
    chk({shutdown_ff, arcLed_ff, buzzer_ff, irq_ff}, 16'h0000);
    for (int a = 0; a < 8; a++) rdchk(a[3:0], rv[a]);
    rdchk(4'hf, 16'h0000);
    wr(`REG_OC_COUNT, 16'h0005);
    rdchk(`REG_OC_COUNT, 16'h0000);
  endtask
  // Arc held four cycles must still count once
  task automatic arc_burst(input logic [1:0] k, input int n);
    for (int j = 0; j < n; j++) begin
      arcKind <= k;
      tick(4);
      chk(shutdown_ff, 16'h0001);
      chk(arcLed_ff, 16'h0001);
      arcKind <= 2'h0;
      tick(6);
      chk(shutdown_ff, 16'h0001);
      firePulse <= 1'h1;
      tick(1);
      firePulse <= 1'h0;
      tick(3);
      chk(shutdown_ff, 16'h0000);
    end
    ocN += n * k[0];
    crN += n * k[1];
    rdchk(`REG_OC_COUNT, ocN[15:0]);
    rdchk(`REG_CROSS_COUNT, crN[15:0]);
  endtask
  task automatic disabled_arcs;
    wr(`REG_CTRL, 16'h0000);
    arcKind <= 2'h3;
    tick(6);
    chk(shutdown_ff, 16'h0000);
    arcKind <= 2'h0;
    tick(2);
    wr(`REG_CTRL, `CTRL_RESET);
    rdchk(`REG_OC_COUNT, ocN[15:0]);
    rdchk(`REG_CROSS_COUNT, crN[15:0]);
  endtask
  task automatic irq_and_clear;
    rdchk(`REG_STATUS, 16'h0003);
    chk(irq_ff, 16'h0000);
    wr(`REG_IRQ_EN, 16'h0001);
    tick(2);
    chk(irq_ff, 16'h0001);
    wr(`REG_IRQ_CLR, 16'h0003);
    tick(2);
    chk(irq_ff, 16'h0000);
    rdchk(`REG_STATUS, 16'h0000);
    wr(`REG_COUNT_CLR, 16'h0001);
    ocN = 0;
    crN = 0;
    rdchk(`REG_OC_COUNT, 16'h0000);
    rdchk(`REG_CROSS_COUNT, 16'h0000);
  endtask
  task automatic buzzer_cycle;
    warning <= 1'h1;
    tick(3);
    chk({buzzer_ff, alarmLed_ff}, 16'h0003);
    press <= 1'h1;
    tick(1);
    press <= 1'h0;
    tick(3);
    chk(buzzer_ff, 16'h0000);
    warning <= 1'h0;
    tick(2);
    alarm <= 1'h1;
    tick(3);
    chk(buzzer_ff, 16'h0001);
    wr(`REG_ALARM_CLR, 16'h0001);
    tick(2);
    chk(buzzer_ff, 16'h0000);
    alarm <= 1'h0;
    rdchk(`REG_STATUS, 16'h0004);
  endtask
  task automatic panel_leds;
    for (int i = 0; i < 16; i++) begin
      poweredUp <= i[0];
      running <= i[1];
      interlockOpen <= i[2];
      doorOpen <= i[3];
      regLoop <= i[3:2];
      tick(3);
      chk({standbyLed_ff, onLed_ff, interlockLed_ff}, {i[0] & ~i[1], i[1], i[2] | i[3]});
      chk({regULed_ff, regILed_ff, regPLed_ff}, {3{i[1]}}
        & {i[3:2] == 2'h1, i[3:2] == 2'h2, i[3:2] == 2'h0});
    end
  endtask
  task automatic bar_levels;
    peakVoltage <= 16'hffff;
    peakCurrent <= 16'h199a;
    peakPower <= 16'h8000;
    tick(3);
    chk(barVoltage, 16'h03ff);
    chk(barCurrent, 16'h0001);
    chk(barPower, 16'h001f);
    peakCurrent <= 16'h1999;
    tick(3);
    chk(barCurrent, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict;
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // Far beyond the few hundred cycles the scenarios need
  initial begin
    #500000;
    errTotal++;
    giveVerdict();
  end
  initial begin
    rst = 1'h1;
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    reset_values();
    wr(`REG_OC_TH, 16'h8000);
    wr(`REG_VLOW_TH, 16'h1000);
    wr(`REG_IHIGH_TH, 16'h4000);
    arc_burst(2'h1, 1);
    arc_burst(2'h2, 1);
    arc_burst(2'h3, 1);
    arc_burst(2'h1, 10);
    disabled_arcs();
    irq_and_clear();
    buzzer_cycle();
    panel_leds();
    bar_levels();
    giveVerdict();
  end
endmodule // arc_annunciator_test
